// ===== host_port_model.sv
// host-side model of the register port: one write or one read at a time
// assumes the block samples its strobes on the rising edge of clk
`timescale 1ns/1ps

module host_port_model (
    // clock
    input  wire logic        clk,
    // register port
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [3:0]       reg_addr,
    output logic [10:0]      reg_wdata,
    input  wire logic [10:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 11'h000;
    end

    // data is inverted once released so a stale word is never mistaken for a live one
    task automatic write_word(input logic [3:0] addr, input logic [10:0] data);
        @(posedge clk);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = addr;
        reg_wdata = data;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~data;
    endtask : write_word

    // address held after the strobe, read data follows it
    task automatic read_word(input logic [3:0] addr, output logic [10:0] data,
                             output logic ok);
        @(posedge clk);
        #1;
        reg_rd   = 1'b1;
        reg_addr = addr;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        ok     = reg_rvalid;
        data   = reg_rdata;
    endtask : read_word
endmodule : host_port_model

// ===== ocp_cfg_defs.svh
// offsets, field positions, reset values and timing figures of the overcurrent and
// sense-amplifier configuration block; assumes a 40 MHz core clock
`ifndef OCP_CFG_DEFS_SVH
`define OCP_CFG_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define GUARD_OFFSET        4'h3
`define CYCLE_CLEAR_OFFSET  4'h4
`define OCP_OFFSET          4'h5
`define AMP_OFFSET          4'h6

// ****************************************************************
// field positions
// ****************************************************************
`define GUARD_MSB           10
`define GUARD_LSB           8
`define CYCLE_CLEAR_BIT     10

// ****************************************************************
// reset values and guard codes
// ****************************************************************
`define OCP_RESET           11'h159
`define AMP_RESET           11'h283
`define CYCLE_CLEAR_RESET   1'h1
`define GUARD_LOCK_CODE     3'h6
`define GUARD_UNLOCK_CODE   3'h3

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS       25
`define DEAD_BASE_NS        50
`define FILTER_STEP_NS      2000
`define RETRY_LONG_MS       4
`define RETRY_SHORT_US      50
`define FILTER_STEP_CYC     (`FILTER_STEP_NS / `CLK_PERIOD_NS)
`define RETRY_LONG_CYC      ((`RETRY_LONG_MS * 1000000) / `CLK_PERIOD_NS)
`define RETRY_SHORT_CYC     ((`RETRY_SHORT_US * 1000) / `CLK_PERIOD_NS)

`endif

// ===== ocp_cfg_pkg.sv
// types of the overcurrent and sense-amplifier configuration block;
// field order of each struct follows the bit layout of its register word
package ocp_cfg_pkg;

    typedef enum logic [1:0] {
        RESP_LATCHED = 2'h0,
        RESP_RETRY   = 2'h1,
        RESP_REPORT  = 2'h2,
        RESP_OFF     = 2'h3
    } resp_mode_t;

    typedef struct packed {
        logic       fault_retry_time_select;
        logic [1:0] dead_time_select;
        resp_mode_t overcurrent_response_select;
        logic [1:0] overcurrent_filter_time;
        logic [3:0] drain_source_trip_level;
    } ocp_cfg_t;

    typedef struct packed {
        logic       amplifier_input_select;
        logic       reference_half_select;
        logic       low_side_measure_reference;
        logic [1:0] amplifier_gain_select;
        logic       sense_fault_disable;
        logic       amp_a_offset_calibrate;
        logic       amp_b_offset_calibrate;
        logic       amp_c_offset_calibrate;
        logic [1:0] sense_trip_level;
    } amp_cfg_t;

endpackage : ocp_cfg_pkg

// ===== overcurrent_and_sense_amp_config.sv
// configuration words for overcurrent protection and the current-sense amplifiers,
// with the overcurrent filter, response and retry logic that they steer
// assumes a decoded serial register port on clk and comparator outputs from the pins
// Summary of operation
// R1 - retry select bit picks 4 ms wait when clear, 50 us when set; resets clear
// R2 - dead-time field gives 50, 100, 200 or 400 ns; resets to 01
// R3 - response code 00 makes overcurrent a latched fault until explicitly cleared
// R4 - response code 01, the reset value, gives a self-clearing retrying fault
// R5 - response code 10 reports overcurrent but leaves the gate outputs alone
// R6 - response code 11 neither reports nor acts on overcurrent
// R7 - filter field gives 2, 4, 6 or 8 us; resets to 01
// R8 - four-bit trip level field from 0.06 V to 1.88 V; resets to 1001
// R9 - input select chooses sense-positive or switch node; setting it forces low-side ref
// R10 - reference divide bit: full reference when clear, half when set; resets set
// R11 - low-side ref bit picks sense-positive or sense-negative for low-side measure
// R12 - gain field gives 5, 10, 20 or 40 V/V; resets to 10
// R13 - sense fault disable bit: fault enabled when clear, the reset state
// R14 - each calibration bit shorts its own amplifier inputs when set
// R15 - sense trip field gives 0.25, 0.5, 0.75 or 1 V; resets to 11
// R16 - amplifier register exists only in variants that carry the amplifiers
// R17 - in retry mode with cycle clear set, a new pwm input clears the fault
// R18 - guard code 110 locks other writes, 011 unlocks, other codes do nothing
// R19 - overcurrent counts only after persisting for the whole filter time
`timescale 1ns/1ps
`include "ocp_cfg_defs.svh"

module overcurrent_and_sense_amp_config #(
    parameter bit HAS_AMPS        = 1'b1,
    parameter int RETRY_LONG_CYC  = `RETRY_LONG_CYC,
    parameter int RETRY_SHORT_CYC = `RETRY_SHORT_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [10:0]          reg_wdata,
    output logic      [10:0]          reg_rdata,
    output logic                      reg_rvalid,
    // monitors and pwm
    input  wire logic                 drain_source_overcurrent_raw,
    input  wire logic                 sense_resistor_overcurrent_raw,
    input  wire logic                 pwm_input,
    input  wire logic                 fault_clear,
    // protection outputs
    output logic                      gate_shutdown,
    output logic                      overcurrent_report,
    output logic                      drain_source_overcurrent,
    output logic                      sense_resistor_overcurrent,
    output logic      [4:0]           dead_time_cycles,
    // configuration outputs
    output ocp_cfg_pkg::ocp_cfg_t     ocp_cfg,
    output ocp_cfg_pkg::amp_cfg_t     amp_cfg
);

    localparam int RETRY_MAX = (RETRY_LONG_CYC > RETRY_SHORT_CYC) ? RETRY_LONG_CYC
                                                                  : RETRY_SHORT_CYC;
    localparam int RETRY_W   = $clog2(RETRY_MAX + 1);

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [8:0] filter_limit(input logic [1:0] code);
        return 9'((32'(code) + 1) * `FILTER_STEP_CYC);
    endfunction : filter_limit

    function automatic logic [4:0] dead_cycles(input logic [1:0] code);
        return 5'((`DEAD_BASE_NS << code) / `CLK_PERIOD_NS);
    endfunction : dead_cycles

    function automatic logic [RETRY_W-1:0] retry_limit(input logic short_sel);
        return short_sel ? RETRY_W'(RETRY_SHORT_CYC) : RETRY_W'(RETRY_LONG_CYC);
    endfunction : retry_limit

    // ****************************************************************
    // registers and guard
    // ****************************************************************
    ocp_cfg_pkg::ocp_cfg_t  ocp_q;
    ocp_cfg_pkg::amp_cfg_t  amp_q;
    logic                   cycle_clear_q;
    logic                   lock_q;
    logic [2:0]             guard_code;
    logic                   guard_wr;
    logic                   cfg_wr_ok;

    assign guard_code = reg_wdata[`GUARD_MSB:`GUARD_LSB];
    assign guard_wr   = reg_wr && (reg_addr == `GUARD_OFFSET);
    assign cfg_wr_ok  = reg_wr && !lock_q; // R18

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lock_q <= 1'b0;
        else if (guard_wr && !lock_q && guard_code == `GUARD_LOCK_CODE)
            lock_q <= 1'b1; // R18
        else if (guard_wr && lock_q && guard_code == `GUARD_UNLOCK_CODE)
            lock_q <= 1'b0; // R18
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ocp_q <= `OCP_RESET; // R1 R2 R4 R7 R8
        else if (cfg_wr_ok && reg_addr == `OCP_OFFSET)
            ocp_q <= reg_wdata;
    end

    // absent amplifiers: word stays at reset and reads as zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            amp_q <= `AMP_RESET; // R10 R12 R13 R15
        else if (HAS_AMPS && cfg_wr_ok && reg_addr == `AMP_OFFSET) // R16
        begin
            amp_q <= reg_wdata;
            // the switch-node input only makes sense with the sense-negative reference
            amp_q.low_side_measure_reference <= reg_wdata[8] | reg_wdata[10]; // R9 R11
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cycle_clear_q <= `CYCLE_CLEAR_RESET;
        else if (cfg_wr_ok && reg_addr == `CYCLE_CLEAR_OFFSET)
            cycle_clear_q <= reg_wdata[`CYCLE_CLEAR_BIT];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= 11'h000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            case (reg_addr)
                `GUARD_OFFSET:
                    reg_rdata <= {(lock_q ? `GUARD_LOCK_CODE : `GUARD_UNLOCK_CODE), 8'h00};
                `CYCLE_CLEAR_OFFSET:
                    reg_rdata <= {cycle_clear_q, 10'h000};
                `OCP_OFFSET:
                    reg_rdata <= ocp_q;
                `AMP_OFFSET:
                    reg_rdata <= HAS_AMPS ? 11'(amp_q) : 11'h000; // R16
                default:
                    reg_rdata <= 11'h000;
            endcase
        end
    end

    assign ocp_cfg = ocp_q;
    assign amp_cfg = HAS_AMPS ? amp_q : amp_cfg_pkg_reset(); // R14 R16

    function automatic ocp_cfg_pkg::amp_cfg_t amp_cfg_pkg_reset();
        return `AMP_RESET;
    endfunction : amp_cfg_pkg_reset

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dead_time_cycles <= 5'h04;
        else
            dead_time_cycles <= dead_cycles(ocp_q.dead_time_select); // R2
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [1:0] raw_in;
    logic [1:0] raw_s1_q;
    logic [1:0] raw_s2_q;
    logic       pwm_s1_q;
    logic       pwm_s2_q;
    logic       pwm_s3_q;
    logic       pwm_edge;

    assign raw_in = {sense_resistor_overcurrent_raw, drain_source_overcurrent_raw};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            raw_s1_q <= 2'h0;
            raw_s2_q <= 2'h0;
            pwm_s1_q <= 1'b0;
            pwm_s2_q <= 1'b0;
            pwm_s3_q <= 1'b0;
        end
        else
        begin
            raw_s1_q <= raw_in;
            raw_s2_q <= raw_s1_q;
            pwm_s1_q <= pwm_input;
            pwm_s2_q <= pwm_s1_q;
            pwm_s3_q <= pwm_s2_q;
        end
    end

    assign pwm_edge = pwm_s2_q && !pwm_s3_q;

    // ****************************************************************
    // overcurrent filter, index 0 drain-source, index 1 sense
    // ****************************************************************
    logic [1:0] qual_in;
    logic [1:0] det;
    logic [8:0] filt_cnt_q [2];
    logic [8:0] filt_lim;

    assign filt_lim   = filter_limit(ocp_q.overcurrent_filter_time); // R7
    assign qual_in[0] = raw_s2_q[0];
    assign qual_in[1] = raw_s2_q[1] && HAS_AMPS && !amp_q.sense_fault_disable; // R13

    for (genvar i = 0; i < 2; i++)
    begin : g_filter
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                filt_cnt_q[i] <= 9'h000;
            else if (!qual_in[i])
                filt_cnt_q[i] <= 9'h000; // R19
            else if (filt_cnt_q[i] < filt_lim)
                filt_cnt_q[i] <= filt_cnt_q[i] + 9'h001; // R19
            else
                filt_cnt_q[i] <= filt_lim;
        end

        assign det[i] = qual_in[i] && (filt_cnt_q[i] >= filt_lim); // R19

        filter_step_a : assert property (@(posedge clk) disable iff (!rst_n) // R19
            $rose(det[i]) |-> $past(filt_cnt_q[i]) == filt_lim - 9'h001)
            else $error("overcurrent seen before the filter time ran out");
    end

    // ****************************************************************
    // response and retry
    // ****************************************************************
    ocp_cfg_pkg::resp_mode_t mode;
    logic                    acting;
    logic                    det_any;
    logic                    fault_q;
    logic [RETRY_W-1:0]      retry_cnt_q;
    logic                    retry_done;
    logic                    cycle_clear;
    logic [1:0]              tripped_q;

    assign mode        = ocp_q.overcurrent_response_select;
    assign acting      = (mode == ocp_cfg_pkg::RESP_LATCHED) || (mode == ocp_cfg_pkg::RESP_RETRY);
    assign det_any     = |det;
    assign retry_done  = (mode == ocp_cfg_pkg::RESP_RETRY) && (retry_cnt_q == RETRY_W'(1));
    assign cycle_clear = (mode == ocp_cfg_pkg::RESP_RETRY) && cycle_clear_q && pwm_edge; // R17

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fault_q <= 1'b0;
        else if (acting && det_any)
            fault_q <= 1'b1; // R3 R4
        else if (!acting)
            fault_q <= 1'b0; // R5 R6
        else if (mode == ocp_cfg_pkg::RESP_LATCHED && fault_clear)
            fault_q <= 1'b0; // R3
        else if (retry_done || cycle_clear)
            fault_q <= 1'b0; // R4 R17
    end

    // the wait restarts while the condition persists, so it times from its end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            retry_cnt_q <= '0;
        else if (mode == ocp_cfg_pkg::RESP_RETRY && det_any)
            retry_cnt_q <= retry_limit(ocp_q.fault_retry_time_select); // R1
        else if (!fault_q || cycle_clear || mode != ocp_cfg_pkg::RESP_RETRY)
            retry_cnt_q <= '0;
        else if (retry_cnt_q != '0)
            retry_cnt_q <= retry_cnt_q - RETRY_W'(1); // R1
    end

    for (genvar i = 0; i < 2; i++)
    begin : g_report
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                tripped_q[i] <= 1'b0;
            else if (det[i] && mode != ocp_cfg_pkg::RESP_OFF)
                tripped_q[i] <= 1'b1; // R5
            else if (mode == ocp_cfg_pkg::RESP_OFF)
                tripped_q[i] <= 1'b0; // R6
            else if (fault_clear || retry_done || cycle_clear)
                tripped_q[i] <= 1'b0;
        end
    end

    assign gate_shutdown              = fault_q && acting; // R5
    assign overcurrent_report         = |tripped_q; // R6
    assign drain_source_overcurrent   = tripped_q[0];
    assign sense_resistor_overcurrent = tripped_q[1];

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_lock_write;
        guard_wr && !lock_q && guard_code == `GUARD_LOCK_CODE;
    endsequence

    sequence s_unlock_write;
        guard_wr && lock_q && guard_code == `GUARD_UNLOCK_CODE;
    endsequence

    guard_lock_a : assert property (@(posedge clk) disable iff (!rst_n) // R18
        s_lock_write |=> lock_q)
        else $error("lock code did not lock");

    guard_unlock_a : assert property (@(posedge clk) disable iff (!rst_n) // R18
        s_unlock_write |=> !lock_q)
        else $error("unlock code did not unlock");

    locked_write_a : assert property (@(posedge clk) disable iff (!rst_n) // R18
        lock_q && reg_wr && reg_addr == `OCP_OFFSET |=> ocp_q == $past(ocp_q))
        else $error("write changed the word while locked");

    latched_hold_a : assert property (@(posedge clk) disable iff (!rst_n) // R3
        fault_q && mode == ocp_cfg_pkg::RESP_LATCHED && !fault_clear
        && $stable(ocp_q) |=> fault_q)
        else $error("latched fault cleared itself");

    retry_load_a : assert property (@(posedge clk) disable iff (!rst_n) // R1
        $rose(fault_q) && mode == ocp_cfg_pkg::RESP_RETRY
        |-> retry_cnt_q == retry_limit(ocp_q.fault_retry_time_select))
        else $error("retry wait loaded with wrong time");

    retry_end_a : assert property (@(posedge clk) disable iff (!rst_n) // R4
        retry_done && !det_any && $stable(ocp_q) ##1 $stable(ocp_q) |-> !fault_q)
        else $error("retrying fault not cleared at end of wait");

    cycle_clear_a : assert property (@(posedge clk) disable iff (!rst_n) // R17
        cycle_clear && !det_any && fault_q |=> !fault_q || $changed(ocp_q))
        else $error("pwm input did not clear the retrying fault");

    report_only_a : assert property (@(posedge clk) disable iff (!rst_n) // R5
        mode == ocp_cfg_pkg::RESP_REPORT && det_any |-> !gate_shutdown ##1 overcurrent_report)
        else $error("report mode acted on the gates or did not report");

    silent_mode_a : assert property (@(posedge clk) disable iff (!rst_n) // R6
        mode == ocp_cfg_pkg::RESP_OFF ##1 mode == ocp_cfg_pkg::RESP_OFF
        |-> !overcurrent_report && !gate_shutdown)
        else $error("silent mode reported or acted");

    input_force_a : assert property (@(posedge clk) disable iff (!rst_n) // R9
        amp_q.amplifier_input_select |-> amp_q.low_side_measure_reference)
        else $error("switch-node input without low-side reference");

endmodule : overcurrent_and_sense_amp_config

// ===== tb.sv
// self-checking bench of the overcurrent and sense-amplifier configuration block
// assumes short retry counts passed as parameters and a 40 MHz clock
`timescale 1ns/1ps
`include "ocp_cfg_defs.svh"

module tb;
    logic                  clk;
    logic                  rst_n;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [3:0]            reg_addr;
    logic [10:0]           reg_wdata;
    logic [10:0]           reg_rdata;
    logic                  reg_rvalid;
    logic                  ds_raw;
    logic                  se_raw;
    logic                  pwm_input;
    logic                  fault_clear;
    logic                  gate_shutdown;
    logic                  overcurrent_report;
    logic                  drain_source_overcurrent;
    logic                  sense_resistor_overcurrent;
    logic [4:0]            dead_time_cycles;
    ocp_cfg_pkg::ocp_cfg_t ocp_cfg;
    ocp_cfg_pkg::amp_cfg_t amp_cfg;
    int                    n_mismatch;
    int                    total_checks;

    // short retry counts keep the run small; 200 still outlasts the long-wait hold check
    overcurrent_and_sense_amp_config #(.HAS_AMPS(1'b1), .RETRY_LONG_CYC(200),
        .RETRY_SHORT_CYC(20)) overcurrent_and_sense_amp_config_inst (
        .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .drain_source_overcurrent_raw(ds_raw),
        .sense_resistor_overcurrent_raw(se_raw), .pwm_input(pwm_input),
        .fault_clear(fault_clear), .gate_shutdown(gate_shutdown),
        .overcurrent_report(overcurrent_report),
        .drain_source_overcurrent(drain_source_overcurrent),
        .sense_resistor_overcurrent(sense_resistor_overcurrent),
        .dead_time_cycles(dead_time_cycles), .ocp_cfg(ocp_cfg), .amp_cfg(amp_cfg));

    host_port_model host_port_model_inst (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
        end
    endtask : tick

    task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    function automatic logic flag(input int k);
        case (k)
            0:       return gate_shutdown;
            1:       return overcurrent_report;
            default: return sense_resistor_overcurrent;
        endcase
    endfunction : flag

    task automatic wait_flag(input int k, input logic v, input int bound, input string name);
        int i;
        for (i = 0; i < bound && flag(k) !== v; i++)
            tick(1);
        check(name, 11'(v), 11'(flag(k)));
        if (flag(k) !== v)
            finish_test();
    endtask : wait_flag

    task automatic rd_chk(input logic [3:0] addr, input logic [10:0] exp, input string name);
        logic [10:0] data;
        logic        ok;
        host_port_model_inst.read_word(addr, data, ok);
        check({name, " valid"}, 11'h001, 11'(ok));
        check(name, exp, data);
    endtask : rd_chk

    task automatic wr(input logic [3:0] addr, input logic [10:0] data);
        host_port_model_inst.write_word(addr, data);
    endtask : wr

    task automatic clear_pulse();
        fault_clear = 1'b1;
        tick(1);
        fault_clear = 1'b0;
    endtask : clear_pulse

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_regs();
        int c;
        rd_chk(`OCP_OFFSET, 11'h159, "ocp reset");
        rd_chk(`AMP_OFFSET, 11'h283, "amp reset");
        rd_chk(`GUARD_OFFSET, 11'h300, "guard reset");
        rd_chk(4'hf, 11'h000, "unmapped read");
        check("dead reset", 11'h004, 11'(dead_time_cycles));
        for (c = 0; c < 4; c++)
        begin
            wr(`OCP_OFFSET, {1'b0, 2'(c), 8'h59});
            tick(1);
            check("dead cycles", 11'(5'h02 << c), 11'(dead_time_cycles));
        end
        wr(`AMP_OFFSET, 11'h400);
        rd_chk(`AMP_OFFSET, 11'h500, "input select forces ref");
        wr(`AMP_OFFSET, 11'h0dc);
        rd_chk(`AMP_OFFSET, 11'h0dc, "gain and cal");
        check("cal a", 11'h001, 11'(amp_cfg.amp_a_offset_calibrate));
        check("gain", 11'h003, 11'(amp_cfg.amplifier_gain_select));
        wr(`AMP_OFFSET, 11'h283);
        $display("test regs done");
    endtask : test_regs

    task automatic test_lock();
        wr(`OCP_OFFSET, 11'h159);
        wr(`GUARD_OFFSET, 11'h600);
        rd_chk(`GUARD_OFFSET, 11'h600, "guard locked");
        wr(`OCP_OFFSET, 11'h000);
        wr(`GUARD_OFFSET, 11'h500);
        wr(`AMP_OFFSET, 11'h000);
        rd_chk(`OCP_OFFSET, 11'h159, "locked ocp");
        rd_chk(`AMP_OFFSET, 11'h283, "locked amp");
        wr(`GUARD_OFFSET, 11'h300);
        wr(`OCP_OFFSET, 11'h2aa);
        rd_chk(`OCP_OFFSET, 11'h2aa, "unlocked ocp");
        check("ocp word", 11'h2aa, 11'(ocp_cfg));
        $display("test lock done");
    endtask : test_lock

    task automatic test_latched();
        wr(`OCP_OFFSET, 11'h109);
        ds_raw = 1'b1;
        tick(40);
        ds_raw = 1'b0;
        tick(100);
        check("short glitch", 11'h000, 11'(gate_shutdown));
        ds_raw = 1'b1;
        tick(70);
        check("before filter end", 11'h000, 11'(gate_shutdown));
        wait_flag(0, 1'b1, 20, "latched trip");
        ds_raw = 1'b0;
        tick(300);
        check("latched holds", 11'h001, 11'(gate_shutdown));
        clear_pulse();
        wait_flag(0, 1'b0, 5, "latched clear");
        $display("test latched done");
    endtask : test_latched

    task automatic test_retry();
        wr(`OCP_OFFSET, 11'h549);
        ds_raw = 1'b1;
        wait_flag(0, 1'b1, 100, "short trip");
        ds_raw = 1'b0;
        tick(10);
        check("short wait holds", 11'h001, 11'(gate_shutdown));
        wait_flag(0, 1'b0, 40, "short release");
        wr(`OCP_OFFSET, 11'h149);
        wr(`CYCLE_CLEAR_OFFSET, 11'h000);
        ds_raw = 1'b1;
        wait_flag(0, 1'b1, 100, "long trip");
        ds_raw = 1'b0;
        tick(5);
        pwm_input = 1'b1;
        tick(4);
        pwm_input = 1'b0;
        tick(140);
        check("long wait holds", 11'h001, 11'(gate_shutdown));
        wait_flag(0, 1'b0, 100, "long release");
        wr(`CYCLE_CLEAR_OFFSET, 11'h400);
        ds_raw = 1'b1;
        wait_flag(0, 1'b1, 100, "cycle trip");
        ds_raw = 1'b0;
        tick(5);
        pwm_input = 1'b1;
        tick(4);
        pwm_input = 1'b0;
        wait_flag(0, 1'b0, 6, "pwm clears");
        $display("test retry done");
    endtask : test_retry

    task automatic test_modes();
        wr(`OCP_OFFSET, 11'h189);
        ds_raw = 1'b1;
        wait_flag(1, 1'b1, 100, "report mode flag");
        check("report no action", 11'h000, 11'(gate_shutdown));
        check("report source", 11'h001, 11'(drain_source_overcurrent));
        ds_raw = 1'b0;
        tick(4);
        clear_pulse();
        wr(`OCP_OFFSET, 11'h1c9);
        ds_raw = 1'b1;
        tick(100);
        check("off no report", 11'h000, 11'(overcurrent_report));
        check("off no action", 11'h000, 11'(gate_shutdown));
        ds_raw = 1'b0;
        tick(4);
        $display("test modes done");
    endtask : test_modes

    task automatic test_sense();
        wr(`OCP_OFFSET, 11'h109);
        wr(`AMP_OFFSET, 11'h2a3);
        se_raw = 1'b1;
        tick(100);
        check("sense disabled", 11'h000, 11'(sense_resistor_overcurrent));
        check("sense disabled gate", 11'h000, 11'(gate_shutdown));
        se_raw = 1'b0;
        wr(`AMP_OFFSET, 11'h283);
        se_raw = 1'b1;
        wait_flag(2, 1'b1, 100, "sense flag");
        check("sense latched gate", 11'h001, 11'(gate_shutdown));
        se_raw = 1'b0;
        tick(4);
        clear_pulse();
        wait_flag(0, 1'b0, 5, "sense clear");
        $display("test sense done");
    endtask : test_sense

    // ****************************************************************
    // clock, reset and sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever
            #12.5 clk = ~clk;
    end

    initial
    begin
        rst_n        = 1'b0;
        ds_raw       = 1'b0;
        se_raw       = 1'b0;
        pwm_input    = 1'b0;
        fault_clear  = 1'b0;
        n_mismatch   = 0;
        total_checks = 0;
        repeat (8)
            @(posedge clk);
        #1;
        rst_n = 1'b1;
        test_regs();
        test_lock();
        test_latched();
        test_retry();
        test_modes();
        test_sense();
        finish_test();
    end
endmodule : tb
